// file: core/isc_pkg.sv
// shared constants and carriers for the input snapshot and change detect core
package isc_pkg;
  localparam int CHANNELS = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int LEVEL_W = 3;
  localparam int VECTOR_W = 8;
  localparam int SEL_W = 3;
  // register selector codes
  localparam logic [SEL_W-1:0] SEL_BOARD_ID = 3'h0;
  localparam logic [SEL_W-1:0] SEL_CONTROL_STATUS = 3'h1;
  localparam logic [SEL_W-1:0] SEL_INPUT_DATA = 3'h2;
  localparam logic [SEL_W-1:0] SEL_FIFO = 3'h3;
  localparam logic [SEL_W-1:0] SEL_INT_PROC = 3'h4;
  localparam logic [SEL_W-1:0] SEL_SELF_TEST = 3'h5;
  // edge select encodings
  localparam logic [1:0] EDGE_DATA_ONLY = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  // byte lane mask and reset values
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [7:0] VECTOR_RESET = 8'h0f;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 3'h1;
  // board id value is arbitrary
  localparam logic [15:0] BOARD_ID_VALUE = 16'h1234;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [3:0] lanes;
  } isc_access_s;

  typedef struct packed {
    logic [CHANNELS-1:0] selHigh;
    logic [CHANNELS-1:0] selLow;
  } isc_edge_cfg_s;
endpackage

// file: core/isc_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module isc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic full,
  output logic empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign full = (count_q == (AW+1)'(DEPTH));
  assign empty = (count_q == '0);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop)
      begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: core/isc_edge_detect.sv
// per-channel edge qualification against edge select bits
`timescale 1ns/1ns
`default_nettype none
module isc_edge_detect
  import isc_pkg::*;
#(
  parameter int N = 32
) (
  input wire logic [N-1:0] oldData,
  input wire logic [N-1:0] newData,
  input wire isc_edge_cfg_s cfg,
  output logic hit
);
  logic [N-1:0] chanHit;
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_chan
      logic rise;
      logic fall;
      assign rise = !oldData[i] && newData[i];
      assign fall = oldData[i] && !newData[i];
      assign chanHit[i] = ({cfg.selHigh[i], cfg.selLow[i]} == EDGE_RISING) ? rise :
                          ({cfg.selHigh[i], cfg.selLow[i]} == EDGE_FALLING) ? fall :
                          ({cfg.selHigh[i], cfg.selLow[i]} == EDGE_ANY) ? (rise || fall) :
                          1'b0;
    end
  endgenerate
  assign hit = |chanHit;
endmodule
`default_nettype wire

// file: core/isc_core.sv
// snapshot read path, change detection and interrupt processor
// Operation
// - a recognised board access latches all inputs into the snapshot register.
// - snapshot data is steered onto the byte lanes the transfer asks for.
// - read data is placed in the same cycle the acknowledge rises; the decoder re-arms once the strobes are released.
// - plain reads are always served and never touch change detection state.
// - a selector picks id, control/status, fifo, interrupt, self-test or input data.
// - change detection decides on a qualifying change, requests and loads the fifo.
// - each request toward the interrupt processor writes the input word to the fifo unless the fifo is full.
// - on a request the interrupt line rises and waits for an acknowledge at its level.
// - a matching acknowledge is answered with the programmed vector.
// - host reads drain the fifo and release-on-empty drops the request when empty.
// - two select bits per channel pick data only, rising, falling or any edge.
// - release-on-empty holds until empty; release-on-ack re-requests on non-empty.
// - an acknowledge with nothing pending passes the daisy chain through.
`timescale 1ns/1ns
`default_nettype none
module isc_core
  import isc_pkg::*;
#(
  parameter int N = CHANNELS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [N-1:0] inputPins,
  input wire logic boardSelect,
  input wire isc_access_s access,
  input wire logic strobesReleased,
  output logic [31:0] readData,
  output logic [3:0] lanesDriven,
  output logic dtack,
  input wire logic [15:0] controlStatus,
  input wire logic [N-1:0] selfTestData,
  input wire logic testMode,
  input wire isc_edge_cfg_s edgeCfg,
  input wire logic changeDetectEnable,
  input wire logic releaseOnFifoEmpty,
  input wire logic interruptEnable,
  input wire logic [LEVEL_W-1:0] irqLevel,
  input wire logic [VECTOR_W-1:0] irqVector,
  input wire logic iackCycle,
  input wire logic [LEVEL_W-1:0] iackLevel,
  input wire logic iackIn,
  output logic iackOut,
  output logic irq,
  output logic fifoFull,
  output logic fifoEmpty
);
  typedef enum logic [1:0] {IDLE, ACKED, WAIT_RELEASE} isc_bus_e;
  typedef enum logic [1:0] {IP_IDLE, IP_ASSERT, IP_HOLD} isc_ip_e;

  logic [N-1:0] pinMeta_q;
  logic [N-1:0] pinSync_q;
  logic [N-1:0] live;
  logic [N-1:0] old_q;
  logic [N-1:0] snapshot_q;
  logic change;
  logic request;
  logic fifoInReady;
  logic fifoValid;
  logic fifoPop;
  logic [N-1:0] fifoData;
  logic armed_q;
  logic [SEL_W-1:0] selLatched_q;
  logic [3:0] lanesLatched_q;
  isc_bus_e bus_q;
  isc_ip_e ip_q;
  logic iackMatch;
  logic [31:0] word;
  logic [31:0] readData_d;

  // pins cross in through two stages
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end
    else
    begin
      pinMeta_q <= inputPins;
      pinSync_q <= pinMeta_q;
    end
  end

  // self-test data only overrides, never reaches the pins
  assign live = testMode ? selfTestData : pinSync_q;

  // own history register, untouched by reads
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      old_q <= '0;
    end
    else
    begin
      old_q <= live;
    end
  end

  isc_edge_detect #(.N(N)) u_detect (
    .oldData(old_q),
    .newData(live),
    .cfg(edgeCfg),
    .hit(change)
  );

  assign request = changeDetectEnable && change;

  // request and fifo write together; full fifo drops the word
  isc_fifo #(.WIDTH(N), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .inValid(request),
    .inReady(fifoInReady),
    .inData(live),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData),
    .full(fifoFull),
    .empty(fifoEmpty)
  );

  // pop as the head is latched
  // popping at the take edge would hand the host the word behind the head
  assign fifoPop = (bus_q == ACKED) && (selLatched_q == SEL_FIFO);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      snapshot_q <= '0;
      selLatched_q <= SEL_BOARD_ID;
      lanesLatched_q <= LANES_NONE;
    end
    else if ((bus_q == IDLE) && boardSelect && armed_q && !iackCycle)
    begin
      snapshot_q <= live;
      selLatched_q <= access.sel;
      lanesLatched_q <= access.lanes;
    end
  end

  always_comb
  begin
    word = DATA_RESET;
    if (selLatched_q == SEL_BOARD_ID)
      word = {16'h0000, BOARD_ID_VALUE};
    else if (selLatched_q == SEL_CONTROL_STATUS)
      word = {16'h0000, controlStatus};
    else if (selLatched_q == SEL_INPUT_DATA)
      word = 32'(snapshot_q);
    else if (selLatched_q == SEL_FIFO)
      word = fifoValid ? 32'(fifoData) : DATA_RESET;
    else if (selLatched_q == SEL_INT_PROC)
      word = {24'h000000, irqVector};
    else if (selLatched_q == SEL_SELF_TEST)
      word = 32'(selfTestData);
  end

  assign iackMatch = iackCycle && (iackLevel == irqLevel);

  // lane steering, unused lanes read zero
  always_comb
  begin
    readData_d = DATA_RESET;
    if (bus_q == ACKED)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (lanesLatched_q[b])
          readData_d[b*8 +: 8] = word[b*8 +: 8];
      end
    end
  end

  // acknowledge then re-arm on strobe release
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bus_q <= IDLE;
      armed_q <= 1'b1;
      dtack <= 1'b0;
      readData <= DATA_RESET;
      lanesDriven <= LANES_NONE;
    end
    else
    begin
      case (bus_q)
        IDLE:
        begin
          dtack <= 1'b0;
          if (!strobesReleased)
            armed_q <= armed_q;
          else
            armed_q <= 1'b1;
          if (boardSelect && armed_q && !iackCycle)
          begin
            bus_q <= ACKED;
            armed_q <= 1'b0;
          end
          else if (iackMatch && irq && armed_q)
          begin
            readData <= {24'h000000, irqVector};
            lanesDriven <= 4'h1;
            dtack <= 1'b1;
            armed_q <= 1'b0;
            bus_q <= WAIT_RELEASE;
          end
        end
        ACKED:
        begin
          readData <= readData_d;
          lanesDriven <= lanesLatched_q;
          dtack <= 1'b1;
          bus_q <= WAIT_RELEASE;
        end
        WAIT_RELEASE:
        begin
          if (strobesReleased)
          begin
            dtack <= 1'b0;
            lanesDriven <= LANES_NONE;
            readData <= DATA_RESET;
            armed_q <= 1'b1;
            bus_q <= IDLE;
          end
        end
        default:
          bus_q <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ip_q <= IP_IDLE;
    end
    else
    begin
      case (ip_q)
        IP_IDLE:
          if (interruptEnable && !fifoEmpty)
            ip_q <= IP_ASSERT;
        IP_ASSERT:
          if (bus_q == IDLE && iackMatch && armed_q)
            ip_q <= releaseOnFifoEmpty ? IP_HOLD : IP_IDLE;
        IP_HOLD:
          if (fifoEmpty)
            ip_q <= IP_IDLE;
        default:
          ip_q <= IP_IDLE;
      endcase
    end
  end

  assign irq = (ip_q == IP_ASSERT) || (ip_q == IP_HOLD && !fifoEmpty);

  // daisy chain pass-through
  // kept low while our own answer stands, even once the request is released
  assign iackOut = iackCycle && iackIn && !(iackMatch && (irq || dtack));

  sequence s_access;
    (bus_q == IDLE) && boardSelect && armed_q && !iackCycle;
  endsequence

  property p_snapshot;
    @(posedge clock) disable iff (rst) s_access |=> (snapshot_q == $past(live));
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot not latched");

  property p_dtack;
    @(posedge clock) disable iff (rst) s_access |=> ##1 dtack;
  endproperty
  a_dtack: assert property (p_dtack) else $error("no acknowledge after access");

  property p_lanes;
    @(posedge clock) disable iff (rst) s_access |=> ##1 (lanesDriven == $past(access.lanes, 2));
  endproperty
  a_lanes: assert property (p_lanes) else $error("wrong lanes driven");

  property p_noread_effect;
    @(posedge clock) disable iff (rst) s_access |=> (old_q == $past(live));
  endproperty
  a_noread_effect: assert property (p_noread_effect) else $error("read disturbed history");

  property p_push;
    @(posedge clock) disable iff (rst)
      (request && !fifoFull) |=> !fifoEmpty;
  endproperty
  a_push: assert property (p_push) else $error("request did not load fifo");

  property p_irq_raise;
    @(posedge clock) disable iff (rst)
      (ip_q == IP_IDLE && interruptEnable && !fifoEmpty) |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

  property p_hold;
    @(posedge clock) disable iff (rst)
      (ip_q == IP_HOLD && !fifoEmpty) |-> irq;
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped before empty");

  property p_pass;
    @(posedge clock) disable iff (rst)
      (iackCycle && iackIn && !irq && !dtack) |-> iackOut;
  endproperty
  a_pass: assert property (p_pass) else $error("daisy chain not passed");

  property p_vector;
    @(posedge clock) disable iff (rst)
      (bus_q == IDLE && !boardSelect && iackMatch && ip_q == IP_ASSERT && armed_q)
      |=> (dtack && readData[7:0] == $past(irqVector));
  endproperty
  a_vector: assert property (p_vector) else $error("vector not answered");
endmodule
`default_nettype wire

// file: tb/isc_host_model.sv
// host cpu model: data reads and interrupt acknowledge cycles
`timescale 1ns/1ns
`default_nettype none
module isc_host_model
  import isc_pkg::*;
(
  input wire logic clock,
  input wire logic [31:0] readData,
  input wire logic [3:0] lanesDriven,
  input wire logic dtack,
  input wire logic iackOut,
  output logic boardSelect,
  output isc_access_s access,
  output logic strobesReleased,
  output logic iackCycle,
  output logic [LEVEL_W-1:0] iackLevel,
  output logic iackIn
);
  int seed = 32'hb3c3;
  initial
  begin
    boardSelect = 0;
    access = '0;
    strobesReleased = 1;
    iackCycle = 0;
    iackLevel = '0;
    iackIn = 0;
  end
  // hold request until acknowledge or 8 clocks, slow release at random
  task automatic cycle(input logic iack, input logic [2:0] lvl, input isc_access_s acc,
    output logic [31:0] d, output logic ok, output logic pass, output logic [3:0] l);
    @(posedge clock);
    boardSelect <= !iack;
    iackCycle <= iack;
    iackIn <= iack;
    iackLevel <= lvl;
    access <= acc;
    strobesReleased <= 0;
    ok = 0;
    for (int n = 0; n < 8 && !ok; n++)
    begin
      @(posedge clock);
      ok = dtack;
      d = readData;
      l = lanesDriven;
      pass = iackOut;
    end
    repeat ({$random(seed)} % 3) @(posedge clock);
    strobesReleased <= 1;
    boardSelect <= 0;
    iackCycle <= 0;
    iackIn <= 0;
    // released lines float, so show a changed pattern
    access <= ~acc;
    iackLevel <= ~lvl;
    repeat (3) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: tb/isc_core_test.sv
// self-checking bench for the snapshot, change detect and interrupt core
`timescale 1ns/1ns
`default_nettype none
module isc_core_test
  import isc_pkg::*;
;
  logic clock;
  logic rst;
  logic [31:0] inputPins;
  logic [31:0] readData;
  logic [31:0] selfTestData;
  logic [31:0] d;
  logic [31:0] q[$];
  logic [3:0] lanesDriven;
  logic [3:0] l;
  logic [15:0] controlStatus;
  logic [2:0] irqLevel;
  logic [2:0] iackLevel;
  logic [7:0] irqVector;
  logic dtack, iackOut, irq, fifoFull, fifoEmpty, ok, pass;
  logic boardSelect, strobesReleased, iackCycle, iackIn, testMode;
  logic changeDetectEnable, releaseOnFifoEmpty, interruptEnable;
  isc_access_s access;
  isc_edge_cfg_s edgeCfg;
  int failures, check_count, seed, n;

  isc_core isc_core_i (.clock(clock), .rst(rst), .inputPins(inputPins),
    .boardSelect(boardSelect), .access(access), .strobesReleased(strobesReleased),
    .readData(readData), .lanesDriven(lanesDriven), .dtack(dtack),
    .controlStatus(controlStatus), .selfTestData(selfTestData), .testMode(testMode),
    .edgeCfg(edgeCfg), .changeDetectEnable(changeDetectEnable),
    .releaseOnFifoEmpty(releaseOnFifoEmpty), .interruptEnable(interruptEnable),
    .irqLevel(irqLevel), .irqVector(irqVector), .iackCycle(iackCycle),
    .iackLevel(iackLevel), .iackIn(iackIn), .iackOut(iackOut), .irq(irq),
    .fifoFull(fifoFull), .fifoEmpty(fifoEmpty));
  isc_host_model isc_host_model_i (.clock(clock), .readData(readData),
    .lanesDriven(lanesDriven), .dtack(dtack), .iackOut(iackOut),
    .boardSelect(boardSelect), .access(access), .strobesReleased(strobesReleased),
    .iackCycle(iackCycle), .iackLevel(iackLevel), .iackIn(iackIn));

  initial
  begin
    clock = 0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rd(input logic [2:0] sel, input logic [3:0] ln);
    isc_host_model_i.cycle(0, '0, '{sel: sel, lanes: ln}, d, ok, pass, l);
  endtask

  task automatic iack(input logic [2:0] lvl);
    isc_host_model_i.cycle(1, lvl, '0, d, ok, pass, l);
  endtask

  function automatic logic [31:0] mask(input logic [3:0] ln);
    for (int b = 0; b < 4; b++)
      mask[8*b +: 8] = {8{ln[b]}};
  endfunction

  // reference: qualify edges per channel, full fifo drops the word
  task automatic drive(input logic [31:0] w);
    logic [31:0] hit;
    hit = (~inputPins & w & edgeCfg.selLow) | (inputPins & ~w & edgeCfg.selHigh);
    if (changeDetectEnable && hit != 0 && q.size() < FIFO_DEPTH)
      q.push_back(w);
    @(posedge clock);
    inputPins <= w;
    repeat (5) @(posedge clock);
  endtask

  // host service: read the fifo until it reports empty
  task automatic drain();
    n = 0;
    while (fifoEmpty === 1'b0 && n < 12)
    begin
      rd(SEL_FIFO, 4'hf);
      chk(d, (n < q.size()) ? q[n] : DATA_RESET);
      n++;
    end
    chk(n, q.size());
    q.delete();
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
  endtask

  initial
  begin
    seed = 32'hb3c3;
    failures = 0;
    check_count = 0;
    rst = 1;
    inputPins = '0;
    controlStatus = '0;
    selfTestData = '0;
    testMode = 0;
    edgeCfg = '0;
    changeDetectEnable = 0;
    releaseOnFifoEmpty = 1;
    interruptEnable = 0;
    irqLevel = 3'h1;
    irqVector = 8'h0f;
    repeat (16) @(posedge clock);
    rst <= 0;
    chk({dtack, irq, fifoFull, fifoEmpty}, 4'h1);
    for (int ln = 1; ln < 16; ln++)
    begin
      drive($random(seed));
      rd(SEL_INPUT_DATA, ln);
      chk(d, inputPins & mask(ln));
      chk(l, ln);
      chk(ok, 1);
    end
    $display("snapshot test done");
    controlStatus <= $random(seed);
    selfTestData <= $random(seed);
    rd(SEL_BOARD_ID, 4'hf);
    chk(d[15:0], BOARD_ID_VALUE);
    rd(SEL_CONTROL_STATUS, 4'hf);
    chk(d[15:0], controlStatus);
    rd(SEL_SELF_TEST, 4'hf);
    chk(d, selfTestData);
    testMode <= 1;
    settle();
    rd(SEL_INPUT_DATA, 4'hf);
    chk(d, selfTestData);
    testMode <= 0;
    $display("selector test done");
    changeDetectEnable <= 1;
    for (int m = 0; m < 4; m++)
    begin
      edgeCfg <= '{selHigh: {32{m[1]}}, selLow: {32{m[0]}}};
      settle();
      drive($random(seed));
      rd(SEL_INPUT_DATA, 4'hf);
      drive(~inputPins);
      chk(irq, 0);
      drain();
    end
    edgeCfg <= {$random(seed), $random(seed)};
    settle();
    repeat (6) drive($random(seed));
    drain();
    edgeCfg <= '1;
    settle();
    repeat (11) drive($random(seed));
    chk(fifoFull, q.size() == FIFO_DEPTH);
    drain();
    $display("edge select test done");
    irqLevel <= 3'h5;
    irqVector <= $random(seed);
    interruptEnable <= 1;
    drive(~inputPins);
    chk(irq, 1);
    drive(~inputPins);
    rd(SEL_INPUT_DATA, 4'hf);
    chk(irq, 1);
    iack(3'h2);
    chk({ok, pass}, 2'h1);
    iack(3'h5);
    chk({ok, pass, d[7:0]}, {2'h2, irqVector});
    chk(irq, 1);
    rd(SEL_FIFO, 4'hf);
    chk(d, q.pop_front());
    chk(irq, 1);
    drain();
    chk(irq, 0);
    $display("release on empty test done");
    releaseOnFifoEmpty <= 0;
    drive(~inputPins);
    iack(3'h5);
    chk(ok, 1);
    chk(irq, 1);
    drain();
    chk(irq, 1);
    iack(3'h5);
    chk(ok, 1);
    settle();
    chk(irq, 0);
    $display("release on acknowledge test done");
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
